// ==== src/lmd_defines.svh ====
// register offsets, field positions, reset values and fixed levels for the local memory dma
// assumes the includer owns the register port and decodes 12 bits of byte offset
`ifndef LMD_DEFINES_SVH
`define LMD_DEFINES_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define LMD_OFF_CH0_STATUS 12'h000
`define LMD_OFF_CH0_MASK   12'h004
`define LMD_OFF_CH0_SRC    12'h008
`define LMD_OFF_CH0_DST    12'h00C
`define LMD_OFF_CH0_COUNT  12'h010
`define LMD_OFF_CH1_STATUS 12'h100
`define LMD_OFF_CH1_SRC    12'h108
`define LMD_OFF_CH1_DST    12'h10C
`define LMD_OFF_CH1_COUNT  12'h110

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define LMD_RUNNING_BIT    0
`define LMD_QUEUED_BIT     1
`define LMD_IRQ_EN_BIT     28
`define LMD_FILL_BIT       16
`define LMD_LEVEL_LSB      29
`define LMD_LEVEL_MSB      31
`define LMD_CH0_BLK_MSB    3
`define LMD_LEN_MSB        15
`define LMD_CH0_PTR_LSB    5
`define LMD_CH1_DST_LSB    2

// ----------------------------------------------------------------------------
// reset values and fixed levels
// ----------------------------------------------------------------------------
`define LMD_RESET_WORD     32'h0000_0000
`define LMD_CH0_LEVEL      3'h0
`define LMD_WORD_BYTES     16'h0004
`define LMD_LAST_WORD      5'h1F

`endif

// ==== src/lmd_pkg.sv ====
// types shared by the local memory dma: parameter sets, memory request, engine states
// assumes lmd_defines.svh is reachable on the include path
`default_nettype none

package lmd_pkg;

  // --------------------------------------------------------------------------
  // parameter sets
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] mask;
    logic [26:0] src;
    logic [26:0] dst;
    logic [3:0]  blocks;
    logic        irq_en;
  } lmd_ch0_set_s;

  typedef struct packed {
    logic [31:0] src;
    logic [29:0] dst;
    logic [15:0] len;
    logic        fill;
    logic        irq_en;
    logic [2:0]  level;
  } lmd_ch1_set_s;

  // --------------------------------------------------------------------------
  // memory request and engine states
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [2:0]  level;
  } lmd_mem_req_s;

  typedef enum logic [3:0] {
    LMD_IDLE  = 4'b0001,
    LMD_STEP  = 4'b0010,
    LMD_READ  = 4'b0100,
    LMD_WRITE = 4'b1000
  } lmd_state_e;

endpackage

`default_nettype wire

// ==== src/lmd_dma_regs.sv ====
// two-channel local memory dma: register file, per-channel queue and one shared word engine
// assumes a single-clock register port from the core and a word memory port that acks requests
//
// Summary of operation
// RULE1: channel zero mask holds 32 bits, one per word of a block.
// RULE2: mask bit zero lets the word move, one blocks it.
// RULE3: software keeps channel zero pointers inside local memories or configuration space.
// RULE4: software makes exactly one channel zero side configuration space.
// RULE5: channel zero source keeps bits 31 to 5; low five read zero.
// RULE6: channel zero destination keeps bits 31 to 5; low five read zero.
// RULE7: channel zero moves block field plus one blocks of 32 words.
// RULE8: same mask every block; addresses advance through contiguous blocks.
// RULE9: channel zero interrupt enable raises done pulse after completion.
// RULE10: reserved count and status bits read zero and ignore writes.
// RULE11: channel one queued flag sets on submit while busy, clears on start.
// RULE12: channel one running flag covers first read to final write.
// RULE13: software puts channel one ends on different ports for throughput.
// RULE14: fill mode skips reads and writes the source value everywhere.
// RULE15: source keeps 32 bits; copies use it with two low bits zero.
// RULE16: channel one destination keeps bits 31 to 2; low two read zero.
// RULE17: channel one level bits 31 to 29 drive memory arbitration priority.
// RULE18: channel one interrupt enable raises done pulse at transfer end.
// RULE19: count bit 16 picks copy when zero, fill when one.
// RULE20: byte length in bits 15 to 0; zero completes at once.
// RULE21: writing the count register submits the transfer.
// RULE22: one running transfer per channel plus one queued set.
// RULE23: masked words are neither read nor written; offsets still advance.
`default_nettype none
`include "lmd_defines.svh"

module lmd_dma_regs
  import lmd_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         reg_sel_i,
  input  wire logic         reg_we_i,
  input  wire logic [11:0]  reg_addr_i,
  input  wire logic [31:0]  reg_wdata_i,
  output logic      [31:0]  reg_rdata_o,
  output logic              reg_ack_o,
  output lmd_mem_req_s      mem_req_o,
  input  wire logic         mem_ack_i,
  input  wire logic [31:0]  mem_rdata_i,
  output logic              ch0_done_irq_o,
  output logic              ch1_done_irq_o
);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [31:0] off_add(input logic [31:0] base, input logic [15:0] off);
    off_add = base + {16'h0000, off};
  endfunction

  // the address is an argument so the decode wires follow every change of it
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic [31:0]  c0_mask_reg;
  logic [26:0]  c0_src_reg;
  logic [26:0]  c0_dst_reg;
  logic [3:0]   c0_blocks_reg;
  logic         c0_irq_en_reg;
  logic [31:0]  c1_src_reg;
  logic [29:0]  c1_dst_reg;
  logic [15:0]  c1_len_reg;
  logic         c1_fill_reg;
  logic         c1_irq_en_reg;
  logic [2:0]   c1_level_reg;

  lmd_ch0_set_s c0_act_reg;
  lmd_ch0_set_s c0_q_reg;
  lmd_ch1_set_s c1_act_reg;
  lmd_ch1_set_s c1_q_reg;
  logic         c0_run_reg;
  logic         c0_queued_reg;
  logic         c1_run_reg;
  logic         c1_queued_reg;

  lmd_state_e   state_reg;
  logic         sel_reg;
  logic [4:0]   c0_word_reg;
  logic [4:0]   c0_blk_reg;
  logic [15:0]  c1_off_reg;
  lmd_mem_req_s mem_req_reg;
  logic [31:0]  rdata_reg;
  logic         ack_reg;
  logic         c0_irq_reg;
  logic         c1_irq_reg;

  // --------------------------------------------------------------------------
  // register decode
  // --------------------------------------------------------------------------
  wire logic wr_any      = reg_sel_i && reg_we_i;
  wire logic wr_c0_mask  = wr_any && hit(reg_addr_i, `LMD_OFF_CH0_MASK);
  wire logic wr_c0_src   = wr_any && hit(reg_addr_i, `LMD_OFF_CH0_SRC);
  wire logic wr_c0_dst   = wr_any && hit(reg_addr_i, `LMD_OFF_CH0_DST);
  wire logic wr_c1_src   = wr_any && hit(reg_addr_i, `LMD_OFF_CH1_SRC);
  wire logic wr_c1_dst   = wr_any && hit(reg_addr_i, `LMD_OFF_CH1_DST);
  // RULE21: count write submits
  wire logic submit0     = wr_any && hit(reg_addr_i, `LMD_OFF_CH0_COUNT);
  wire logic submit1     = wr_any && hit(reg_addr_i, `LMD_OFF_CH1_COUNT);

  // submitted set: held mask and pointers plus the count word
  wire lmd_ch0_set_s new0 = '{mask:   c0_mask_reg,
                              src:    c0_src_reg,
                              dst:    c0_dst_reg,
                              blocks: reg_wdata_i[`LMD_CH0_BLK_MSB:0],
                              irq_en: reg_wdata_i[`LMD_IRQ_EN_BIT]};
  wire lmd_ch1_set_s new1 = '{src:    c1_src_reg,
                              dst:    c1_dst_reg,
                              len:    reg_wdata_i[`LMD_LEN_MSB:0],
                              fill:   reg_wdata_i[`LMD_FILL_BIT],
                              irq_en: reg_wdata_i[`LMD_IRQ_EN_BIT],
                              level:  reg_wdata_i[`LMD_LEVEL_MSB:`LMD_LEVEL_LSB]};

  // RULE10: reserved fields read as zero
  wire logic [31:0] rd_c0_count = {3'h0, c0_irq_en_reg, 24'h00_0000, c0_blocks_reg};
  wire logic [31:0] rd_c1_count = {c1_level_reg, c1_irq_en_reg, 11'h000, c1_fill_reg,
                                   c1_len_reg};
  // RULE5: low pointer bits read zero
  wire logic [31:0] rd_c0_src   = {c0_src_reg, 5'h00};
  // RULE6: low pointer bits read zero
  wire logic [31:0] rd_c0_dst   = {c0_dst_reg, 5'h00};
  // RULE16: low two bits read zero
  wire logic [31:0] rd_c1_dst   = {c1_dst_reg, 2'h0};
  wire logic [31:0] rd_val =
    (reg_addr_i == `LMD_OFF_CH0_STATUS) ? {30'h0000_0000, c0_queued_reg, c0_run_reg} :
    (reg_addr_i == `LMD_OFF_CH0_MASK)   ? c0_mask_reg :
    (reg_addr_i == `LMD_OFF_CH0_SRC)    ? rd_c0_src :
    (reg_addr_i == `LMD_OFF_CH0_DST)    ? rd_c0_dst :
    (reg_addr_i == `LMD_OFF_CH0_COUNT)  ? rd_c0_count :
    (reg_addr_i == `LMD_OFF_CH1_STATUS) ? {30'h0000_0000, c1_queued_reg, c1_run_reg} :
    (reg_addr_i == `LMD_OFF_CH1_SRC)    ? c1_src_reg :
    (reg_addr_i == `LMD_OFF_CH1_DST)    ? rd_c1_dst :
    (reg_addr_i == `LMD_OFF_CH1_COUNT)  ? rd_c1_count : `LMD_RESET_WORD;

  // --------------------------------------------------------------------------
  // engine decode
  // --------------------------------------------------------------------------
  wire logic [4:0]  c0_end   = {1'b0, c0_act_reg.blocks} + 5'h01;
  // RULE7: blocks field plus one
  wire logic        c0_done  = (c0_blk_reg == c0_end);
  // RULE20: zero length finishes at once
  wire logic        c1_done  = (c1_off_reg >= c1_act_reg.len);
  wire logic        cur_done = sel_reg ? c1_done : c0_done;
  // RULE2: set bit blocks the word
  wire logic        cur_skip = !sel_reg && c0_act_reg.mask[c0_word_reg];
  // RULE14: fill never reads
  wire logic        cur_fill = sel_reg && c1_act_reg.fill;
  // RULE8: contiguous blocks, same mask
  wire logic [15:0] c0_off   = {5'h00, c0_blk_reg[3:0], c0_word_reg, 2'h0};
  // RULE15: copy source drops two low bits
  wire logic [31:0] c1_rd    = off_add({c1_act_reg.src[31:2], 2'h0}, c1_off_reg);
  wire logic [31:0] rd_addr  = sel_reg ? c1_rd
                                       : off_add({c0_act_reg.src, 5'h00}, c0_off);
  wire logic [31:0] wr_addr  = sel_reg ? off_add({c1_act_reg.dst, 2'h0}, c1_off_reg)
                                       : off_add({c0_act_reg.dst, 5'h00}, c0_off);
  // RULE17: channel one level drives arbitration
  wire logic [2:0]  cur_lvl  = sel_reg ? c1_act_reg.level : `LMD_CH0_LEVEL;
  wire logic        in_step  = (state_reg == LMD_STEP);
  wire logic        finish0  = in_step && cur_done && !sel_reg;
  wire logic        finish1  = in_step && cur_done && sel_reg;
  // RULE23: masked words still advance
  wire logic        advance  = (in_step && !cur_done && cur_skip) ||
                               ((state_reg == LMD_WRITE) && mem_ack_i);

  // --------------------------------------------------------------------------
  // channel queue control; a submit in the finishing cycle is never lost
  // --------------------------------------------------------------------------
  // RULE22: one running, one queued
  wire logic start0   = submit0 && (!c0_run_reg || (finish0 && !c0_queued_reg));
  wire logic promote0 = finish0 && c0_queued_reg;
  wire logic start1   = submit1 && (!c1_run_reg || (finish1 && !c1_queued_reg));
  wire logic promote1 = finish1 && c1_queued_reg;
  // RULE11: set on busy submit, clear on start
  wire logic c0_queued_next = (submit0 && !start0) || (c0_queued_reg && !finish0);
  wire logic c1_queued_next = (submit1 && !start1) || (c1_queued_reg && !finish1);
  // RULE12: running until last write
  wire logic c0_run_next    = start0 || promote0 || (c0_run_reg && !finish0);
  wire logic c1_run_next    = start1 || promote1 || (c1_run_reg && !finish1);

  // --------------------------------------------------------------------------
  // programmed registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      c0_mask_reg   <= `LMD_RESET_WORD;
      c0_src_reg    <= '0;
      c0_dst_reg    <= '0;
      c0_blocks_reg <= '0;
      c0_irq_en_reg <= 1'b0;
      c1_src_reg    <= `LMD_RESET_WORD;
      c1_dst_reg    <= '0;
      c1_len_reg    <= '0;
      c1_fill_reg   <= 1'b0;
      c1_irq_en_reg <= 1'b0;
      c1_level_reg  <= '0;
    end else begin
      // RULE1: full 32 bit mask
      if (wr_c0_mask) c0_mask_reg <= reg_wdata_i;
      if (wr_c0_src) c0_src_reg <= reg_wdata_i[31:`LMD_CH0_PTR_LSB];
      if (wr_c0_dst) c0_dst_reg <= reg_wdata_i[31:`LMD_CH0_PTR_LSB];
      if (submit0) begin
        c0_blocks_reg <= new0.blocks;
        c0_irq_en_reg <= new0.irq_en;
      end
      if (wr_c1_src) c1_src_reg <= reg_wdata_i;
      if (wr_c1_dst) c1_dst_reg <= reg_wdata_i[31:`LMD_CH1_DST_LSB];
      if (submit1) begin
        c1_len_reg    <= new1.len;
        // RULE19: fill select bit
        c1_fill_reg   <= new1.fill;
        c1_irq_en_reg <= new1.irq_en;
        c1_level_reg  <= new1.level;
      end
    end
  end

  // --------------------------------------------------------------------------
  // parameter sets and flags
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      c0_act_reg    <= '0;
      c0_q_reg      <= '0;
      c1_act_reg    <= '0;
      c1_q_reg      <= '0;
      c0_run_reg    <= 1'b0;
      c0_queued_reg <= 1'b0;
      c1_run_reg    <= 1'b0;
      c1_queued_reg <= 1'b0;
    end else begin
      c0_run_reg    <= c0_run_next;
      c0_queued_reg <= c0_queued_next;
      c1_run_reg    <= c1_run_next;
      c1_queued_reg <= c1_queued_next;
      if (start0) c0_act_reg <= new0;
      else if (promote0) c0_act_reg <= c0_q_reg;
      if (submit0 && !start0) c0_q_reg <= new0;
      if (start1) c1_act_reg <= new1;
      else if (promote1) c1_act_reg <= c1_q_reg;
      if (submit1 && !start1) c1_q_reg <= new1;
    end
  end

  // --------------------------------------------------------------------------
  // word engine
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg   <= LMD_IDLE;
      sel_reg     <= 1'b0;
      mem_req_reg <= '0;
    end else begin
      unique case (state_reg)
        LMD_IDLE: begin
          // channel zero first; a transfer
          // keeps the engine until its end
          if (c0_run_reg) begin
            sel_reg   <= 1'b0;
            state_reg <= LMD_STEP;
          end else if (c1_run_reg) begin
            sel_reg   <= 1'b1;
            state_reg <= LMD_STEP;
          end
        end
        LMD_STEP: begin
          if (cur_done) begin
            state_reg <= LMD_IDLE;
          end else if (!cur_skip) begin
            mem_req_reg <= '{valid: 1'b1,
                             we:    cur_fill,
                             addr:  cur_fill ? wr_addr : rd_addr,
                             wdata: cur_fill ? c1_act_reg.src : `LMD_RESET_WORD,
                             level: cur_lvl};
            state_reg   <= cur_fill ? LMD_WRITE : LMD_READ;
          end
        end
        LMD_READ: begin
          if (mem_ack_i) begin
            mem_req_reg.we    <= 1'b1;
            mem_req_reg.addr  <= wr_addr;
            mem_req_reg.wdata <= mem_rdata_i;
            state_reg         <= LMD_WRITE;
          end
        end
        LMD_WRITE: begin
          if (mem_ack_i) begin
            mem_req_reg.valid <= 1'b0;
            mem_req_reg.we    <= 1'b0;
            state_reg         <= LMD_STEP;
          end
        end
        default: state_reg <= LMD_IDLE;
      endcase
    end
  end

  // counters clear on finish so each set starts at zero
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      c0_word_reg <= '0;
      c0_blk_reg  <= '0;
      c1_off_reg  <= '0;
    end else if (finish0) begin
      c0_word_reg <= '0;
      c0_blk_reg  <= '0;
    end else if (finish1) begin
      c1_off_reg <= '0;
    end else if (advance && !sel_reg) begin
      c0_word_reg <= c0_word_reg + 5'h01;
      if (c0_word_reg == `LMD_LAST_WORD) c0_blk_reg <= c0_blk_reg + 5'h01;
    end else if (advance) begin
      c1_off_reg <= c1_off_reg + `LMD_WORD_BYTES;
    end
  end

  // --------------------------------------------------------------------------
  // register answers and done pulses
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_reg  <= `LMD_RESET_WORD;
      ack_reg    <= 1'b0;
      c0_irq_reg <= 1'b0;
      c1_irq_reg <= 1'b0;
    end else begin
      ack_reg <= reg_sel_i;
      if (reg_sel_i && !reg_we_i) rdata_reg <= rd_val;
      // RULE9: pulse when enabled
      c0_irq_reg <= finish0 && c0_act_reg.irq_en;
      // RULE18: pulse when enabled
      c1_irq_reg <= finish1 && c1_act_reg.irq_en;
    end
  end

  assign reg_rdata_o    = rdata_reg;
  assign reg_ack_o      = ack_reg;
  assign mem_req_o      = mem_req_reg;
  assign ch0_done_irq_o = c0_irq_reg;
  assign ch1_done_irq_o = c1_irq_reg;

endmodule

`default_nettype wire

// ==== bench/lmd_dma_regs_properties.sv ====
// concurrent checks on the local memory dma ports
// assumes it is bound to lmd_dma_regs and sees only that module's ports
`default_nettype none
`include "lmd_defines.svh"

module lmd_dma_regs_chk
  import lmd_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         rst_b_i,
  input wire logic         reg_sel_i,
  input wire logic         reg_we_i,
  input wire logic [11:0]  reg_addr_i,
  input wire logic [31:0]  reg_wdata_i,
  input wire logic [31:0]  reg_rdata_o,
  input wire logic         reg_ack_o,
  input wire lmd_mem_req_s mem_req_o,
  input wire logic         mem_ack_i,
  input wire logic [31:0]  mem_rdata_i,
  input wire logic         ch0_done_irq_o,
  input wire logic         ch1_done_irq_o
);
  logic [31:0] mask_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // mask shadow from write data
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) mask_reg <= 32'h0000_0000;
    else if (reg_sel_i && reg_we_i && reg_addr_i == `LMD_OFF_CH0_MASK) mask_reg <= reg_wdata_i;
  end

  // --------------------------------------------------------------------------
  // sequences and properties
  // --------------------------------------------------------------------------
  sequence s_rd(logic [11:0] a);
    reg_sel_i && !reg_we_i && reg_addr_i == a;
  endsequence
  sequence s_mem_read_done;
    mem_req_o.valid && !mem_req_o.we && mem_ack_i;
  endsequence

  a_ack_after_sel: assert property (reg_sel_i |=> reg_ack_o)
    else $error("no ack");
  a_ack_only_sel: assert property (!reg_sel_i |=> !reg_ack_o)
    else $error("stray ack");
  a_mask_readback: assert property (s_rd(`LMD_OFF_CH0_MASK) |=> reg_rdata_o == mask_reg)
    else $error("mask readback");
  a_ch0_ptr_low: assert property (s_rd(`LMD_OFF_CH0_SRC) or s_rd(`LMD_OFF_CH0_DST)
    |=> reg_rdata_o[4:0] == 5'h00) else $error("ch0 ptr low bits");
  a_ch1_dst_low: assert property (s_rd(`LMD_OFF_CH1_DST) |=> reg_rdata_o[1:0] == 2'b00)
    else $error("ch1 dst low bits");
  a_status_reserved: assert property (s_rd(`LMD_OFF_CH0_STATUS) or s_rd(`LMD_OFF_CH1_STATUS)
    |=> reg_rdata_o[31:2] == 30'h0) else $error("status reserved");
  a_req_held: assert property (mem_req_o.valid && !mem_ack_i |=> $stable(mem_req_o))
    else $error("request moved");
  a_copy_write: assert property (s_mem_read_done |=> mem_req_o.valid && mem_req_o.we
    && mem_req_o.wdata == $past(mem_rdata_i)) else $error("copy data");
  a_word_aligned: assert property (mem_req_o.valid |-> mem_req_o.addr[1:0] == 2'b00)
    else $error("unaligned request");
  a_ch0_irq_pulse: assert property (ch0_done_irq_o |=> !ch0_done_irq_o)
    else $error("ch0 done too long");
  a_ch1_irq_pulse: assert property (ch1_done_irq_o |=> !ch1_done_irq_o)
    else $error("ch1 done too long");
endmodule

bind lmd_dma_regs lmd_dma_regs_chk lmd_dma_regs_chk_inst (.*);

`default_nettype wire

// ==== bench/lmd_mem_model.sv ====
// local memory model for the dma word port, logging accepted requests
// assumes one request held until acked; slow_i adds three wait cycles
`default_nettype none

module lmd_mem_model
  import lmd_pkg::*;
#(
  parameter logic [31:0] RD_KEY = 32'h5A5A_5A5A
)(
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         slow_i,
  input  wire lmd_mem_req_s mem_req_i,
  output logic              mem_ack_o,
  output logic       [31:0] mem_rdata_o
);
  logic [31:0] rd_addr_q [$];
  logic [31:0] wr_addr_q [$];
  logic [31:0] wr_data_q [$];
  logic [2:0]  wr_level_q [$];
  int          wait_cnt;

  task automatic clear_log();
    rd_addr_q.delete();
    wr_addr_q.delete();
    wr_data_q.delete();
    wr_level_q.delete();
  endtask

  // read data is valid only with the acknowledge; otherwise it toggles every cycle
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mem_ack_o   <= 1'b0;
      mem_rdata_o <= 32'h0000_0000;
      wait_cnt    <= 0;
    end else if (mem_ack_o) begin
      mem_ack_o   <= 1'b0;
      wait_cnt    <= 0;
      mem_rdata_o <= ~mem_rdata_o;
      if (mem_req_i.we) begin
        wr_addr_q.push_back(mem_req_i.addr);
        wr_data_q.push_back(mem_req_i.wdata);
        wr_level_q.push_back(mem_req_i.level);
      end else begin
        rd_addr_q.push_back(mem_req_i.addr);
      end
    end else if (mem_req_i.valid && wait_cnt >= (slow_i ? 3 : 0)) begin
      mem_ack_o   <= 1'b1;
      mem_rdata_o <= mem_req_i.addr ^ RD_KEY;
    end else begin
      wait_cnt    <= mem_req_i.valid ? wait_cnt + 1 : 0;
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
endmodule

`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench for the dma register block
// assumes the memory model on the word port and the bound property checker
`default_nettype none
`include "lmd_defines.svh"
`define CHK(a, e, m) begin checked++; if ((a) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: %s", $time, m); end end

module tb
  import lmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] KEY = 32'h5A5A_5A5A;
  logic         clk_i = 1'b0;
  logic         rst_b_i = 1'b0;
  logic         reg_sel_i = 1'b0;
  logic         reg_we_i = 1'b0;
  logic [11:0]  reg_addr_i = 12'h000;
  logic [31:0]  reg_wdata_i = 32'h0000_0000;
  logic [31:0]  reg_rdata_o;
  logic         reg_ack_o;
  lmd_mem_req_s mem_req_o;
  logic         mem_ack_i;
  logic [31:0]  mem_rdata_i;
  logic         ch0_done_irq_o;
  logic         ch1_done_irq_o;
  logic         slow = 1'b0;
  logic [31:0]  rdv;
  int           num_errors = 0;
  int           checked = 0;
  int           cycles = 0;
  int           irq0_cnt = 0;
  int           irq1_cnt = 0;
  int           off;
  logic [11:0]  woff [8] = '{`LMD_OFF_CH0_MASK, `LMD_OFF_CH0_SRC, `LMD_OFF_CH0_DST,
    `LMD_OFF_CH1_SRC, `LMD_OFF_CH1_DST, `LMD_OFF_CH0_STATUS, `LMD_OFF_CH1_STATUS, 12'h020};
  logic [31:0]  wexp [8] = '{32'hFFFF_FFFF, 32'hFFFF_FFE0, 32'hFFFF_FFE0, 32'hFFFF_FFFF,
    32'hFFFF_FFFC, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

  lmd_dma_regs lmd_dma_regs_inst (.*);
  lmd_mem_model #(.RD_KEY(KEY)) lmd_mem_model_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .slow_i(slow), .mem_req_i(mem_req_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

  always #12.5 clk_i = ~clk_i;

  // --------------------------------------------------------------------------
  // access tasks, cycle watch and verdict
  // --------------------------------------------------------------------------
  task automatic end_sim();
    if (num_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic acc(input logic we, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_sel_i   <= 1'b1;
    reg_we_i    <= we;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_sel_i <= 1'b0;
    #1;
    `CHK(reg_ack_o, 1'b1, "no ack")
    rdv = reg_rdata_o;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input string m);
    acc(1'b0, a, 32'h0000_0000);
    `CHK(rdv, e, m)
  endtask

  // bounded poll
  task automatic wait_idle(input logic [11:0] a);
    int n;
    n = 0;
    rdv = 32'h0000_0001;
    while (rdv !== 32'h0000_0000 && n < 500) begin
      acc(1'b0, a, 32'h0000_0000);
      n++;
    end
    `CHK(rdv, 32'h0000_0000, "busy")
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (ch0_done_irq_o === 1'b1) irq0_cnt++;
    if (ch1_done_irq_o === 1'b1) irq1_cnt++;
    if (cycles == 6000) begin
      num_errors++;
      end_sim();
    end
  end

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    foreach (woff[i]) rd_chk(woff[i], 32'h0000_0000, "reset value");
    rd_chk(`LMD_OFF_CH0_COUNT, 32'h0000_0000, "ch0 count reset");
    rd_chk(`LMD_OFF_CH1_COUNT, 32'h0000_0000, "ch1 count reset");
    foreach (woff[i]) begin
      acc(1'b1, woff[i], 32'hFFFF_FFFF);
      rd_chk(woff[i], wexp[i], "readback");
    end
    // two masked blocks from configuration space into local ram, slow memory
    @(posedge clk_i);
    slow <= 1'b1;
    lmd_mem_model_inst.clear_log();
    acc(1'b1, `LMD_OFF_CH0_MASK, 32'h7FFF_FFFA);
    acc(1'b1, `LMD_OFF_CH0_SRC, 32'h0000_1000);
    acc(1'b1, `LMD_OFF_CH0_DST, 32'h0000_2000);
    acc(1'b1, `LMD_OFF_CH0_COUNT, 32'hF000_00F1);
    rd_chk(`LMD_OFF_CH0_COUNT, 32'h1000_0001, "ch0 count readback");
    wait_idle(`LMD_OFF_CH0_STATUS);
    `CHK(irq0_cnt, 1, "ch0 done count")
    `CHK(lmd_mem_model_inst.rd_addr_q.size(), 6, "ch0 reads")
    for (int i = 0; i < 6; i++) begin
      off = (i / 3) * 128 + ((i % 3 == 0) ? 0 : (i % 3 == 1) ? 8 : 124);
      `CHK(lmd_mem_model_inst.rd_addr_q[i], 32'h1000 + off, "ch0 source")
      `CHK(lmd_mem_model_inst.wr_addr_q[i], 32'h2000 + off, "ch0 dest")
      `CHK(lmd_mem_model_inst.wr_data_q[i], (32'h1000 + off) ^ KEY, "ch0 data")
    end
    // one block, one open word, no interrupt
    lmd_mem_model_inst.clear_log();
    acc(1'b1, `LMD_OFF_CH0_MASK, 32'hFFFF_FFDF);
    acc(1'b1, `LMD_OFF_CH0_COUNT, 32'h0000_0000);
    wait_idle(`LMD_OFF_CH0_STATUS);
    `CHK(irq0_cnt, 1, "ch0 irq while disabled")
    `CHK(lmd_mem_model_inst.wr_addr_q.size(), 1, "ch0 single block")
    `CHK(lmd_mem_model_inst.wr_addr_q[0], 32'h0000_2014, "ch0 open word")
    // copy running with a fill queued behind it
    lmd_mem_model_inst.clear_log();
    acc(1'b1, `LMD_OFF_CH1_SRC, 32'h0000_3003);
    acc(1'b1, `LMD_OFF_CH1_DST, 32'h0000_4000);
    acc(1'b1, `LMD_OFF_CH1_COUNT, 32'hB000_0008);
    acc(1'b1, `LMD_OFF_CH1_SRC, 32'hCAFE_F00D);
    acc(1'b1, `LMD_OFF_CH1_DST, 32'h0000_5000);
    acc(1'b1, `LMD_OFF_CH1_COUNT, 32'h4FFF_000C);
    rd_chk(`LMD_OFF_CH1_STATUS, 32'h0000_0003, "running and queued");
    rd_chk(`LMD_OFF_CH1_COUNT, 32'h4001_000C, "ch1 count readback");
    wait_idle(`LMD_OFF_CH1_STATUS);
    `CHK(irq1_cnt, 1, "ch1 done count")
    `CHK(lmd_mem_model_inst.rd_addr_q.size(), 2, "fill must not read")
    `CHK(lmd_mem_model_inst.wr_addr_q.size(), 5, "ch1 write count")
    for (int i = 0; i < 5; i++) begin
      off = (i < 2) ? 32'h4000 + 4 * i : 32'h5000 + 4 * (i - 2);
      `CHK(lmd_mem_model_inst.wr_addr_q[i], off, "ch1 dest")
      `CHK(lmd_mem_model_inst.wr_data_q[i], (i < 2) ? (32'h3000 + 4 * i) ^ KEY
        : 32'hCAFE_F00D, "ch1 data")
      `CHK(lmd_mem_model_inst.wr_level_q[i], (i < 2) ? 3'd5 : 3'd2, "ch1 level")
    end
    `CHK(lmd_mem_model_inst.rd_addr_q[1], 32'h0000_3004, "copy source")
    // zero length completes at once with its interrupt
    lmd_mem_model_inst.clear_log();
    acc(1'b1, `LMD_OFF_CH1_COUNT, 32'h1000_0000);
    repeat (6) @(posedge clk_i);
    `CHK(irq1_cnt, 2, "zero length done")
    `CHK(lmd_mem_model_inst.wr_addr_q.size(), 0, "zero length moved data")
    end_sim();
  end
endmodule

`default_nettype wire
